// *** sbl_host.sv ***
`timescale 1ns/1ps
// Host side of the serial link: sends framed bytes, collects the echoes
module sbl_host (
    input  wire logic        i_clk,      // System clock
    input  wire logic [15:0] i_bit_clks, // Clocks per serial bit
    input  wire logic        i_txd,      // Device serial output
    output logic             o_rxd       // Line into the device
);
    logic [7:0] rxq[$];
    logic [7:0] rx_byte;
    int         n_bad = 0;
    int         i;

    initial o_rxd = 1'b1;

    // Start low, eight data bits LSB first, one high stop, then idle high
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        begin
            frame = {1'b1, b, 1'b0};
            for (int k = 0; k < 10; k++) begin
                o_rxd = frame[k];
                repeat (i_bit_clks) @(posedge i_clk);
                #1;
            end
        end
    endtask

    // Receiver samples mid-bit and counts bad stop bits
    always begin
        @(negedge i_txd);
        repeat (i_bit_clks / 2) @(posedge i_clk);
        for (i = 0; i < 8; i++) begin
            repeat (i_bit_clks) @(posedge i_clk);
            rx_byte[i] = i_txd;
        end
        repeat (i_bit_clks) @(posedge i_clk);
        if (i_txd !== 1'b1) n_bad++;
        rxq.push_back(rx_byte);
    end
endmodule

// *** sbl_loader.sv ***
`timescale 1ns/1ps
// Functional notes
// - Boot sequence starts immediately when reset is released in boot mode.
// - Time low period of each zero byte; load derived divisor.
// - After divisor set, send a zero byte as adjustment end.
// - After 0x55, erase flash if written, then send 0xAA.
// - Erase failure sends 0xFF and halts the sequence.
// - Echo both length bytes in arrival order.
// - Echo each program byte and write it to successive RAM locations.
// - After N bytes, send 0xAA as transfer complete.
// - Then jump to start of loaded RAM program. This code skips the jump when N = 0 and waits for a new length.
// - Frame: low start, data LSB first, optional parity, high stop. This code sends and expects no parity bit (8N1 only).
module sbl_loader #(
    parameter int        RAM_AW   = 16,
    parameter logic [15:0] RAM_BASE = 16'h0000
) (
    input  wire logic                 i_clk_sys,     // System clock
    input  wire logic                 i_rst_b,       // Async reset, active low
    input  wire logic                 i_boot_mode,   // Boot mode strap pin
    input  wire logic                 i_rxd,         // Serial receive pin
    output logic                      o_txd,         // Serial transmit pin
    input  wire logic                 i_flash_written, // Flash holds data
    output logic                      o_erase_req,   // Erase pulse
    input  wire logic                 i_erase_done,  // Erase finished pulse
    input  wire logic                 i_erase_fail,  // Erase result, valid with done
    output sbl_pkg::sbl_ram_wr_type   o_ram_wr,      // RAM write address and data
    output logic                      o_ram_we,      // RAM write strobe
    output logic                      o_jump,        // Branch to loaded program
    output logic [15:0]               o_jump_addr,   // Branch target
    output logic [15:0]               o_divisor,     // Baud rate divisor in clocks per bit
    output logic                      o_halted       // Sequence aborted
);
    logic rst_s1_reg, rst_b_reg;
    logic rx_s1_reg, rx_reg, boot_s1_reg, boot_reg;
    // Reset release through two flops
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_s1_reg <= 1'b0;
            rst_b_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_b_reg  <= rst_s1_reg;
        end
    end
    // Pin synchronisers
    always_ff @(posedge i_clk_sys or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            rx_s1_reg   <= 1'b1;
            rx_reg      <= 1'b1;
            boot_s1_reg <= 1'b0;
            boot_reg    <= 1'b0;
        end else begin
            rx_s1_reg   <= i_rxd;
            rx_reg      <= rx_s1_reg;
            boot_s1_reg <= i_boot_mode;
            boot_reg    <= boot_s1_reg;
        end
    end

    sbl_pkg::sbl_state_type state_reg, state_next;
    logic [15:0] div_reg, low_cnt_reg, len_reg, idx_reg;
    logic        rx_d_reg, measuring_reg, started_reg;
    // Receiver
    logic [15:0] rcnt_reg;
    logic [3:0]  rbit_reg;
    logic [7:0]  rsh_reg;
    logic        rbusy_reg, rx_vld_reg, rx_ferr_reg;
    logic [7:0]  rx_byte_reg;
    // Two-entry transmit buffer
    logic [7:0]  buf_mem [2];
    logic        wr_ptr_reg, rd_ptr_reg;
    logic [1:0]  cnt_reg;
    // Transmitter
    logic [15:0] tcnt_reg;
    logic [3:0]  tbit_reg;
    logic [9:0]  tsh_reg;
    logic        tbusy_reg;

    wire fall    = rx_d_reg && !rx_reg;
    wire rise    = !rx_d_reg && rx_reg;
    wire tx_in_rdy = (cnt_reg != 2'd2);
    wire tx_out_vld = (cnt_reg != 2'd0);
    wire tx_pop  = tx_out_vld && !tbusy_reg;
    wire is_prog_byte = (state_reg == sbl_pkg::SBL_PROG) && rx_vld_reg && !rx_ferr_reg;
    wire rx_ok   = rx_vld_reg && !rx_ferr_reg;
    // Push a byte into the buffer; the ack, erase-result and done states wait on tx_in_rdy, the echo states push without it
    logic       push;
    logic [7:0] push_data;
    wire [15:0] meas_div = low_cnt_reg / 16'(sbl_pkg::LOW_BITS);
    wire [15:0] half_div = {1'b0, div_reg[15:1]};

    // Sequencer next state and pushes
    always_comb begin
        state_next = state_reg;
        push       = 1'b0;
        push_data  = sbl_pkg::ZERO_BYTE;
        case (state_reg)
            sbl_pkg::SBL_MEASURE: ; // Measuring handled in clocked logic
            sbl_pkg::SBL_SEND_ACK: if (tx_in_rdy) begin
                push = 1'b1;
                push_data = sbl_pkg::ZERO_BYTE;
                state_next = sbl_pkg::SBL_WAIT_CONF;
            end
            sbl_pkg::SBL_WAIT_CONF: if (rx_ok && rx_byte_reg == sbl_pkg::CONFIRM_BYTE) begin
                state_next = i_flash_written ? sbl_pkg::SBL_ERASE : sbl_pkg::SBL_SEND_DONE;
            end
            sbl_pkg::SBL_ERASE: state_next = sbl_pkg::SBL_WAIT_ERASE;
            sbl_pkg::SBL_WAIT_ERASE: if (i_erase_done && tx_in_rdy) begin
                push = 1'b1;
                push_data = i_erase_fail ? sbl_pkg::FAIL_BYTE : sbl_pkg::DONE_BYTE;
                state_next = i_erase_fail ? sbl_pkg::SBL_HALT : sbl_pkg::SBL_LEN_HI;
            end
            sbl_pkg::SBL_LEN_HI: if (rx_ok) begin
                push = 1'b1;
                push_data = rx_byte_reg;
                state_next = sbl_pkg::SBL_LEN_LO;
            end
            sbl_pkg::SBL_LEN_LO: if (rx_ok) begin
                push = 1'b1;
                push_data = rx_byte_reg;
                state_next = ({len_reg[15:8], rx_byte_reg} == 16'h0000) ?
                             sbl_pkg::SBL_SEND_DONE : sbl_pkg::SBL_PROG;
            end
            sbl_pkg::SBL_PROG: if (is_prog_byte) begin
                push = 1'b1;
                push_data = rx_byte_reg;
                if (idx_reg + 16'h0001 == len_reg) state_next = sbl_pkg::SBL_SEND_DONE;
            end
            sbl_pkg::SBL_SEND_DONE: if (tx_in_rdy) begin
                push = 1'b1;
                push_data = sbl_pkg::DONE_BYTE;
                // Skipped erase or empty length waits for a length; a full load branches
                state_next = (started_reg && len_reg != 16'h0000) ?
                             sbl_pkg::SBL_JUMP : sbl_pkg::SBL_LEN_HI;
            end
            sbl_pkg::SBL_JUMP: ;
            sbl_pkg::SBL_HALT: ;
            default: state_next = sbl_pkg::SBL_HALT;
        endcase
    end

    // Sequencer registers; starts once reset lifts in boot mode
    always_ff @(posedge i_clk_sys or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            state_reg <= sbl_pkg::SBL_MEASURE;
            div_reg <= 16'hffff;
            low_cnt_reg <= 16'h0000;
            measuring_reg <= 1'b0;
            rx_d_reg <= 1'b1;
            len_reg <= 16'h0000;
            idx_reg <= 16'h0000;
            started_reg <= 1'b0;
            o_erase_req <= 1'b0;
            o_ram_we <= 1'b0;
            o_ram_wr <= '0;
            o_jump <= 1'b0;
            o_jump_addr <= 16'h0000;
            o_halted <= 1'b0;
            o_divisor <= 16'hffff;
        end else begin
            rx_d_reg <= rx_reg;
            o_erase_req <= (state_reg == sbl_pkg::SBL_ERASE);
            o_ram_we <= 1'b0;
            if (boot_reg || state_reg != sbl_pkg::SBL_MEASURE) begin
                state_reg <= state_next;
            end
            if (state_reg == sbl_pkg::SBL_MEASURE && boot_reg) begin
                // Time the low run of a zero byte; a run giving a divisor below MIN_DIV is dropped
                if (fall) begin
                    measuring_reg <= 1'b1;
                    low_cnt_reg <= 16'h0001;
                end else if (measuring_reg && !rx_reg && low_cnt_reg != 16'hffff) begin
                    low_cnt_reg <= low_cnt_reg + 16'h0001;
                end else if (measuring_reg && rise) begin
                    measuring_reg <= 1'b0;
                    if (meas_div >= sbl_pkg::MIN_DIV) begin
                        div_reg <= meas_div;
                        o_divisor <= meas_div;
                        state_reg <= sbl_pkg::SBL_SEND_ACK;
                    end
                end
            end
            if (state_reg == sbl_pkg::SBL_LEN_HI && rx_ok) begin
                len_reg <= {rx_byte_reg, 8'h00};
                idx_reg <= 16'h0000;
                started_reg <= 1'b0;
            end
            if (state_reg == sbl_pkg::SBL_LEN_LO && rx_ok) begin
                len_reg <= {len_reg[15:8], rx_byte_reg};
                started_reg <= 1'b1;
            end
            if (is_prog_byte) begin
                o_ram_we <= 1'b1;
                o_ram_wr.addr <= RAM_BASE + idx_reg;
                o_ram_wr.data <= rx_byte_reg;
                idx_reg <= idx_reg + 16'h0001;
            end
            if (state_reg == sbl_pkg::SBL_SEND_DONE && tx_in_rdy && started_reg) begin
                started_reg <= 1'b0;
            end
            if (state_reg == sbl_pkg::SBL_JUMP && !tx_out_vld && !tbusy_reg) begin
                o_jump <= 1'b1;
                o_jump_addr <= RAM_BASE;
            end
            if (state_reg == sbl_pkg::SBL_HALT) o_halted <= 1'b1;
        end
    end

    // Receiver, 8N1, mid-bit sampling after divisor is set
    always_ff @(posedge i_clk_sys or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            rcnt_reg <= 16'h0000;
            rbit_reg <= 4'h0;
            rsh_reg <= 8'h00;
            rbusy_reg <= 1'b0;
            rx_vld_reg <= 1'b0;
            rx_ferr_reg <= 1'b0;
            rx_byte_reg <= 8'h00;
        end else begin
            rx_vld_reg <= 1'b0;
            if (state_reg == sbl_pkg::SBL_MEASURE) begin
                rbusy_reg <= 1'b0;
            end else if (!rbusy_reg) begin
                if (fall) begin
                    rbusy_reg <= 1'b1;
                    rcnt_reg <= half_div;
                    rbit_reg <= 4'h0;
                end
            end else if (rcnt_reg != 16'h0000) begin
                rcnt_reg <= rcnt_reg - 16'h0001;
            end else begin
                rcnt_reg <= div_reg - 16'h0001;
                rbit_reg <= rbit_reg + 4'h1;
                if (rbit_reg == 4'h0 && rx_reg) begin
                    rbusy_reg <= 1'b0; // False start
                end else if (rbit_reg == 4'(sbl_pkg::DATA_BITS + 1)) begin
                    rbusy_reg <= 1'b0;
                    rx_vld_reg <= 1'b1;
                    rx_ferr_reg <= !rx_reg;
                    rx_byte_reg <= rsh_reg;
                end else if (rbit_reg != 4'h0) begin
                    rsh_reg <= {rx_reg, rsh_reg[7:1]};
                end
            end
        end
    end

    // Two-entry buffer and transmitter
    always_ff @(posedge i_clk_sys or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg <= 2'd0;
            buf_mem[0] <= 8'h00;
            buf_mem[1] <= 8'h00;
            tcnt_reg <= 16'h0000;
            tbit_reg <= 4'h0;
            tsh_reg <= 10'h3ff;
            tbusy_reg <= 1'b0;
            o_txd <= 1'b1;
        end else begin
            if (push && tx_in_rdy) begin
                buf_mem[wr_ptr_reg] <= push_data;
                wr_ptr_reg <= !wr_ptr_reg;
            end
            cnt_reg <= cnt_reg + 2'((push && tx_in_rdy) ? 1 : 0) - 2'(tx_pop ? 1 : 0);
            if (tx_pop) begin
                rd_ptr_reg <= !rd_ptr_reg;
                tsh_reg <= {1'b1, buf_mem[rd_ptr_reg], 1'b0};
                tbusy_reg <= 1'b1;
                tbit_reg <= 4'h0;
                tcnt_reg <= div_reg - 16'h0001;
                o_txd <= 1'b0;
            end else if (tbusy_reg) begin
                if (tcnt_reg != 16'h0000) begin
                    tcnt_reg <= tcnt_reg - 16'h0001;
                end else if (tbit_reg == 4'(sbl_pkg::DATA_BITS + 1)) begin
                    tbusy_reg <= 1'b0;
                    o_txd <= 1'b1;
                end else begin
                    tcnt_reg <= div_reg - 16'h0001;
                    tbit_reg <= tbit_reg + 4'h1;
                    tsh_reg <= {1'b1, tsh_reg[9:1]};
                    o_txd <= tsh_reg[1];
                end
            end
        end
    end

    // Ack byte goes out only after the divisor has been loaded
    a_ack_after_div: assert property (@(posedge i_clk_sys) disable iff (!rst_b_reg)
        (state_reg == sbl_pkg::SBL_SEND_ACK) |-> (div_reg == o_divisor))
        else $error("ack sent before divisor load");
    // Each program byte is written to RAM with the received data one cycle later
    a_ram_step: assert property (@(posedge i_clk_sys) disable iff (!rst_b_reg)
        is_prog_byte |=> o_ram_we && o_ram_wr.data == $past(rx_byte_reg))
        else $error("program byte not stored");
    // Erase failure halts within two cycles
    a_fail_halts: assert property (@(posedge i_clk_sys) disable iff (!rst_b_reg)
        (state_reg == sbl_pkg::SBL_WAIT_ERASE && i_erase_done && i_erase_fail && tx_in_rdy)
        |=> state_reg == sbl_pkg::SBL_HALT ##1 o_halted)
        else $error("erase failure did not halt");
    // Jump only happens with the transmitter idle
    a_jump_idle: assert property (@(posedge i_clk_sys) disable iff (!rst_b_reg)
        $rose(o_jump) |-> $past(state_reg) == sbl_pkg::SBL_JUMP && o_jump_addr == RAM_BASE
        && !$past(tx_out_vld) && !$past(tbusy_reg))
        else $error("jump without completion");
    // Buffer never overflows
    a_buf_bound: assert property (@(posedge i_clk_sys) disable iff (!rst_b_reg)
        cnt_reg <= 2'd2) else $error("buffer overflow");
    // Erase request follows the erase state
    a_erase_req: assert property (@(posedge i_clk_sys) disable iff (!rst_b_reg)
        state_reg == sbl_pkg::SBL_ERASE |=> o_erase_req)
        else $error("erase not requested");
    // Transmitted frame starts with a low start bit
    a_start_low: assert property (@(posedge i_clk_sys) disable iff (!rst_b_reg)
        tx_pop |=> !o_txd)
        else $error("start bit not low");
    // Sequencer stays still until boot mode is seen
    a_boot_gate: assert property (@(posedge i_clk_sys) disable iff (!rst_b_reg)
        !boot_reg && state_reg == sbl_pkg::SBL_MEASURE |=> state_reg == sbl_pkg::SBL_MEASURE)
        else $error("left measure outside boot mode");
endmodule

// *** sbl_pkg.sv ***
package sbl_pkg;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;
    localparam logic [7:0] CONFIRM_BYTE = 8'h55;
    localparam logic [7:0] DONE_BYTE    = 8'haa;
    localparam logic [7:0] FAIL_BYTE    = 8'hff;
    localparam int         CLK_HZ       = 40000000;
    localparam int         DATA_BITS    = 8;
    // A zero byte is low for start plus eight data bits
    localparam int         LOW_BITS     = 9;
    localparam logic [15:0] MIN_DIV     = 16'h0002;

    typedef enum {
        SBL_MEASURE, SBL_SEND_ACK, SBL_WAIT_CONF, SBL_ERASE, SBL_WAIT_ERASE,
        SBL_LEN_HI, SBL_LEN_LO, SBL_PROG, SBL_SEND_DONE, SBL_JUMP, SBL_HALT
    } sbl_state_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } sbl_ram_wr_type;
endpackage

// *** tb_serial_boot_loader.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_serial_boot_loader;
    localparam logic [15:0] BASE = 16'h0100;
    logic                   i_clk_sys = 1'b0;
    logic                   i_rst_b, i_boot_mode, i_rxd, o_txd, i_flash_written;
    logic                   o_erase_req, i_erase_done, i_erase_fail, fail_mode;
    logic                   o_ram_we, o_jump, o_halted;
    sbl_pkg::sbl_ram_wr_type o_ram_wr;
    logic [15:0]            o_jump_addr, o_divisor, bit_clks, ram_addr;
    logic [7:0]             expq[$], ramq[$], ram_exp;
    logic [31:0]            seed = 32'ha07949cd;
    int                     mismatches = 0, n_compared = 0, n_erase, cycles = 0;

    always #12.5 i_clk_sys = ~i_clk_sys;

    sbl_loader #(.RAM_AW(16), .RAM_BASE(BASE)) DUT (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_boot_mode(i_boot_mode), .i_rxd(i_rxd), .o_txd(o_txd),
        .i_flash_written(i_flash_written), .o_erase_req(o_erase_req),
        .i_erase_done(i_erase_done), .i_erase_fail(i_erase_fail), .o_ram_wr(o_ram_wr),
        .o_ram_we(o_ram_we), .o_jump(o_jump), .o_jump_addr(o_jump_addr),
        .o_divisor(o_divisor), .o_halted(o_halted));

    sbl_host host (.i_clk(i_clk_sys), .i_bit_clks(bit_clks), .i_txd(o_txd), .o_rxd(i_rxd));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic finish_test();
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 80000) begin
            mismatches++;
            finish_test();
        end
    end

    // Flash model answers each erase pulse after a short busy time
    always begin
        @(posedge i_clk_sys);
        if (o_erase_req === 1'b1) begin
            n_erase++;
            repeat (12) @(posedge i_clk_sys);
            #1 i_erase_done = 1'b1;
            i_erase_fail = fail_mode;
            @(posedge i_clk_sys);
            #1 i_erase_done = 1'b0;
            i_erase_fail = 1'b0;
        end
    end

    // RAM writes land at successive addresses with the echoed data
    always @(posedge i_clk_sys) begin
        if (o_ram_we === 1'b1) begin
            ram_exp = (ramq.size() > 0) ? ramq.pop_front() : 8'hxx;
            `CHK("ram_addr", ram_addr, o_ram_wr.addr)
            `CHK("ram_data", ram_exp, o_ram_wr.data)
            ram_addr = ram_addr + 16'h0001;
        end
    end

    task automatic wait_rx(input int k);
        int t;
        begin
            t = 0;
            while (host.rxq.size() < k && t < 4000) begin
                @(posedge i_clk_sys);
                t++;
            end
            #1;
        end
    endtask

    // Compare each byte the model expects, in order, with the next byte seen from the device
    task automatic drain();
        logic [8:0] e, g;
        begin
            wait_rx(expq.size());
            while (expq.size() > 0) begin
                e = {1'b0, expq.pop_front()};
                g = (host.rxq.size() > 0) ? {1'b0, host.rxq.pop_front()} : 9'h1ff;
                `CHK("tx_byte", e, g)
            end
        end
    endtask

    // Length high then low, N program bytes, then the done byte
    task automatic load(input int n);
        logic [7:0] d;
        begin
            d = 8'(n >> 8);
            expq.push_back(d);
            host.send_byte(d);
            d = 8'(n);
            expq.push_back(d);
            host.send_byte(d);
            for (int k = 0; k < n; k++) begin
                d = 8'(rnd());
                expq.push_back(d);
                ramq.push_back(d);
                host.send_byte(d);
            end
            expq.push_back(sbl_pkg::DONE_BYTE);
            drain();
            // Host has the last byte at mid stop bit; let the device finish that bit
            repeat (bit_clks) @(posedge i_clk_sys);
            #1;
        end
    endtask

    task automatic run(input logic wr, input logic fl, input int n);
        int k;
        begin
            i_flash_written = wr;
            fail_mode = fl;
            n_erase = 0;
            ram_addr = BASE;
            bit_clks = 16'd16 + 16'(rnd() & 32'hf);
            i_rst_b = 1'b0;
            repeat (5) @(posedge i_clk_sys);
            #1 i_rst_b = 1'b1;
            repeat (6) @(posedge i_clk_sys);
            #1;
            expq.push_back(sbl_pkg::ZERO_BYTE);
            for (k = 0; k < 8 && host.rxq.size() == 0; k++) begin
                host.send_byte(sbl_pkg::ZERO_BYTE);
            end
            drain();
            `CHK("divisor", bit_clks, o_divisor)
            host.send_byte(8'h12);
            host.send_byte(sbl_pkg::CONFIRM_BYTE);
            expq.push_back(fl ? sbl_pkg::FAIL_BYTE : sbl_pkg::DONE_BYTE);
            drain();
            `CHK("erase_req", wr, (n_erase > 0))
            if (fl) begin
                host.send_byte(8'h01);
                wait_rx(1);
                `CHK("halted", 1'b1, o_halted)
                `CHK("extra_rx", 0, host.rxq.size())
            end else begin
                if (n == 0) begin
                    load(0);
                    `CHK("jump_early", 1'b0, o_jump)
                    n = 3;
                end
                load(n);
                `CHK("jump", 1'b1, o_jump)
                `CHK("jump_addr", BASE, o_jump_addr)
                `CHK("ram_left", 0, ramq.size())
            end
            `CHK("bad_stop", 0, host.n_bad)
        end
    endtask

    initial begin
        i_rst_b = 1'b0;
        i_boot_mode = 1'b0;
        i_flash_written = 1'b0;
        i_erase_done = 1'b0;
        i_erase_fail = 1'b0;
        fail_mode = 1'b0;
        bit_clks = 16'd20;
        ram_addr = BASE;
        // Strap low: the loader must stay silent and keep its reset divisor
        repeat (5) @(posedge i_clk_sys);
        #1 i_rst_b = 1'b1;
        repeat (6) @(posedge i_clk_sys);
        #1;
        host.send_byte(sbl_pkg::ZERO_BYTE);
        wait_rx(1);
        `CHK("no_boot_rx", 0, host.rxq.size())
        `CHK("no_boot_div", 16'hffff, o_divisor)
        i_boot_mode = 1'b1;
        run(1'b1, 1'b0, 5);
        run(1'b0, 1'b0, 0);
        run(1'b1, 1'b1, 0);
        finish_test();
    end
endmodule
